// ---- rtl/far_result_output.sv ----
// Result output stage of the floating add unit with an APB register slave.
//
// Overview of operation
// - Double precision delivers sum 0..47, or sum 1..48 on overflow.
// - Three segment gates plus double precision select choose the output.
// - Middle segment, double precision with overflow, outputs shifted sum bits 45..48.
// - Middle segment, SP with overflow, outputs shifted sum bits 49..53.
// - Middle segment, double precision without overflow, outputs sum bits 45..47.
// - Middle segment, SP without overflow, outputs sum bits 48..53.
// - Middle gate off drives ones on middle-sourced output bits.
// - Sum bits 54..96 pass only with upper gate; overflow picks shift.
// - Sum bits 0..44 pass only with lower gate; overflow picks shift.
// - Overflow shift is end-off; unused high sum positions drive nothing.
// - Exponent is handled in the fourth period from gate, signs, borrow.
// - Exponent gate off blocks both paths and drives all ones.
// - Alike signs: borrow flags overflow and exponent is incremented.
// - Unlike signs: borrow tells larger operand and fixes result sign.
// - Both positive, no overflow: plain true exponent, bias, positive.
// - Unlike signs, positive larger: positive sign, plain true exponent.
// - Increment path serves positive overflow, negative overflow, negative larger.
// - Positive overflow: exponent plus one, true form, bias, positive sign.
// - Positive overflow turning minus one into negative zero gives positive zero.
// - Unlike signs, negative larger: add zero, ones complement, negative sign.
// - Exponent always lands in result bits 48..59.
// - Single precision delivers sum 48..95, or sum 49..96 on overflow.
// - Overflow is flagged only when operand signs are alike.
`timescale 1ns/1ps
module far_result_output
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [96:0]          coef_sum,
    input  wire logic [10:0]          work_exponent,
    input  wire logic                 sign_j,
    input  wire logic                 sign_k,
    input  wire logic                 top_borrow_out,
    input  wire far_pkg::far_gates_t  gates,
    input  wire logic                 fourth_period,
    output far_pkg::far_result_t      result,
    output logic                      result_valid
);

    // ************************************************************
    // Segment decoding
    // ************************************************************
    function automatic far_pkg::far_seg_t seg_of(input int idx);
        if (idx <= far_pkg::LOWER_TOP)
            seg_of = far_pkg::FAR_SEG_LOWER;
        else if (idx <= far_pkg::MIDDLE_TOP)
            seg_of = far_pkg::FAR_SEG_MIDDLE;
        else
            seg_of = far_pkg::FAR_SEG_UPPER;
    endfunction : seg_of

    function automatic logic seg_gate(input far_pkg::far_seg_t s,
                                      input far_pkg::far_gates_t g);
        case (s)
            far_pkg::FAR_SEG_LOWER:  seg_gate = g.gate_lower;
            far_pkg::FAR_SEG_MIDDLE: seg_gate = g.gate_middle;
            far_pkg::FAR_SEG_UPPER:  seg_gate = g.gate_upper;
            default:                 seg_gate = 1'b0;
        endcase
    endfunction : seg_gate

    logic        enable;
    logic        alike;
    logic        overflow;
    logic        result_negative;
    logic        use_increment;
    logic        negzero_fix;
    logic [11:0] exp_sum;
    logic [10:0] exp_incr;
    logic [10:0] exp_path;
    logic [10:0] exp_biased;
    logic [11:0] next_exp_field;
    logic [47:0] next_coef;

    // ************************************************************
    // Overflow and sign decision
    // ************************************************************
    assign alike           = (sign_j == sign_k);
    // A positive pair overflows with no borrow into the top; a negative pair with one.
    assign overflow        = alike && (sign_j ? top_borrow_out : !top_borrow_out);
    // Unlike signs: borrow set means the negative operand was larger.
    assign result_negative = alike ? sign_j : top_borrow_out;
    assign use_increment   = overflow || (!alike && top_borrow_out);

    // ************************************************************
    // Coefficient selection
    // ************************************************************
    // Each output bit finds its sum bit from precision and shift; the segment
    // holding that bit decides whether it passes or reads as one. Sum bit 0 on
    // a shift and the positions above 96 have no output, so the shift is end-off.
    generate
        for (genvar i = 0; i < far_pkg::COEF_W; i++)
        begin : g_coef
            localparam int DBL_PLAIN = i;
            localparam int DBL_SHIFT = i + 1;
            localparam int SP_PLAIN = far_pkg::SP_BASE + i;
            localparam int SP_SHIFT = far_pkg::SP_BASE + i + 1;
            always_comb
            begin
                if (gates.double_precision_select && !overflow)
                    next_coef[i] = seg_gate(seg_of(DBL_PLAIN), gates)
                                   ? coef_sum[DBL_PLAIN] : 1'b1;
                else if (gates.double_precision_select)
                    next_coef[i] = seg_gate(seg_of(DBL_SHIFT), gates)
                                   ? coef_sum[DBL_SHIFT] : 1'b1;
                else if (!overflow)
                    next_coef[i] = seg_gate(seg_of(SP_PLAIN), gates)
                                   ? coef_sum[SP_PLAIN] : 1'b1;
                else
                    next_coef[i] = seg_gate(seg_of(SP_SHIFT), gates)
                                   ? coef_sum[SP_SHIFT] : 1'b1;
            end
        end
    endgenerate

    // ************************************************************
    // Exponent paths
    // ************************************************************
    // Ones-complement add of the overflow bit with end-around carry.
    assign exp_sum     = {1'b0, work_exponent} + {11'h000, overflow};
    assign exp_incr    = exp_sum[10:0] + {10'h000, exp_sum[11]};
    assign negzero_fix = overflow && !sign_j && (work_exponent == far_pkg::EXP_NEG_ONE);

    always_comb
    begin
        if (!use_increment)
            exp_path = work_exponent;
        else if (negzero_fix)
            exp_path = far_pkg::EXP_POS_ZERO;
        else
            exp_path = exp_incr;
    end

    assign exp_biased = exp_path ^ far_pkg::EXP_BIAS;

    always_comb
    begin
        if (!gates.gate_exponent)
            next_exp_field = 12'hfff;
        else if (result_negative)
            next_exp_field = ~{1'b0, exp_biased};
        else
            next_exp_field = {1'b0, exp_biased};
    end

    // ************************************************************
    // Result register
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            result <= '0;
        end
        else if (fourth_period && enable)
        begin
            result.coef      <= next_coef;
            result.exp_field <= next_exp_field;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            result_valid <= 1'b0;
        else
            result_valid <= fourth_period && enable;
    end

    logic last_overflow;
    logic last_sign;
    logic last_negzero;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            last_overflow <= 1'b0;
            last_sign     <= 1'b0;
            last_negzero  <= 1'b0;
        end
        else if (fourth_period && enable)
        begin
            last_overflow <= overflow;
            last_sign     <= result_negative;
            last_negzero  <= negzero_fix && gates.gate_exponent;
        end
    end

    // ************************************************************
    // APB slave
    // ************************************************************
    logic       setup;
    logic       access;
    logic [3:0] reg_addr;
    logic       mapped;

    assign setup    = psel && !penable;
    assign access   = psel && penable;
    assign reg_addr = paddr[3:0];
    assign mapped   = (paddr[31:4] == 28'h0000000) && (paddr[1:0] == 2'h0);
    assign pready   = 1'b1;
    assign pslverr  = access && !mapped;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            enable <= far_pkg::CTRL_RESET;
        else if (access && pwrite && mapped && reg_addr == far_pkg::CTRL_OFF)
            enable <= pwdata[far_pkg::CTRL_EN_BIT];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (setup)
        begin
            prdata <= 32'h00000000;
            if (mapped)
            begin
                case (reg_addr)
                    far_pkg::CTRL_OFF:      prdata[far_pkg::CTRL_EN_BIT] <= enable;
                    far_pkg::STATUS_OFF:
                    begin
                        prdata[far_pkg::ST_OVF_BIT]  <= last_overflow;
                        prdata[far_pkg::ST_SIGN_BIT] <= last_sign;
                        prdata[far_pkg::ST_NZ_BIT]   <= last_negzero;
                    end
                    far_pkg::RESULT_LO_OFF: prdata <= result[31:0];
                    far_pkg::RESULT_HI_OFF: prdata <= {4'h0, result[59:32]};
                    default:                prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_take;
        fourth_period && enable;
    endsequence

    sequence s_full_gates;
        gates.gate_upper && gates.gate_middle && gates.gate_lower && gates.gate_exponent;
    endsequence

    a_valid_timing: assert property (@(posedge pclk) disable iff (!presetn)
        s_take |=> result_valid)
        else $error("result_valid missing after a fourth period");

    a_exp_gate_ones: assert property (@(posedge pclk) disable iff (!presetn)
        s_take ##0 !gates.gate_exponent |=> result.exp_field == 12'hfff)
        else $error("gated exponent not all ones");

    a_dp_plain_coef: assert property (@(posedge pclk) disable iff (!presetn)
        s_take ##0 s_full_gates ##0 (gates.double_precision_select && !overflow)
        |=> result.coef == $past(coef_sum[47:0]))
        else $error("double precision plain coefficient wrong");

    a_sp_shift_coef: assert property (@(posedge pclk) disable iff (!presetn)
        s_take ##0 s_full_gates ##0 (!gates.double_precision_select && overflow)
        |=> result.coef == $past(coef_sum[96:49]))
        else $error("single precision shifted coefficient wrong");

    a_middle_gate_ones: assert property (@(posedge pclk) disable iff (!presetn)
        s_take ##0 (!gates.gate_middle && !gates.double_precision_select && !overflow)
        |=> result.coef[5:0] == 6'h3f)
        else $error("middle segment not ones when gated off");

    a_unlike_no_ovf: assert property (@(posedge pclk) disable iff (!presetn)
        (sign_j != sign_k) |-> !overflow)
        else $error("overflow flagged for unlike signs");

    a_negzero_fix: assert property (@(posedge pclk) disable iff (!presetn)
        s_take ##0 (gates.gate_exponent && !sign_j && !sign_k && !top_borrow_out
        && work_exponent == 11'h7fe) |=> result.exp_field == 12'h400)
        else $error("negative zero exponent escaped");

    a_neg_larger_sign: assert property (@(posedge pclk) disable iff (!presetn)
        s_take ##0 (gates.gate_exponent && sign_j != sign_k && top_borrow_out)
        |=> result.exp_field == ~{1'b0, $past(work_exponent) ^ 11'h400})
        else $error("negative larger exponent not complemented unchanged");

    a_pos_plain_exp: assert property (@(posedge pclk) disable iff (!presetn)
        s_take ##0 (gates.gate_exponent && !sign_j && !sign_k && top_borrow_out)
        |=> result.exp_field == {1'b0, $past(work_exponent) ^ 11'h400})
        else $error("positive plain exponent wrong");

    a_dp_shift_coef: assert property (@(posedge pclk) disable iff (!presetn)
        s_take ##0 s_full_gates ##0 (gates.double_precision_select && overflow)
        |=> result.coef == $past(coef_sum[48:1]))
        else $error("double precision shifted coefficient wrong");

    a_sp_plain_coef: assert property (@(posedge pclk) disable iff (!presetn)
        s_take ##0 s_full_gates ##0 (!gates.double_precision_select && !overflow)
        |=> result.coef == $past(coef_sum[95:48]))
        else $error("single precision plain coefficient wrong");

    a_mid_dp_shift: assert property (@(posedge pclk) disable iff (!presetn)
        s_take ##0 (gates.double_precision_select && gates.gate_middle && overflow)
        |=> result.coef[47:44] == $past(coef_sum[48:45]))
        else $error("middle segment shifted double precision wrong");

    a_mid_sp_shift: assert property (@(posedge pclk) disable iff (!presetn)
        s_take ##0 (!gates.double_precision_select && gates.gate_middle && overflow)
        |=> result.coef[4:0] == $past(coef_sum[53:49]))
        else $error("middle segment shifted single precision wrong");

    a_mid_dp_plain: assert property (@(posedge pclk) disable iff (!presetn)
        s_take ##0 (gates.double_precision_select && gates.gate_middle && !overflow)
        |=> result.coef[47:45] == $past(coef_sum[47:45]))
        else $error("middle segment plain double precision wrong");

    a_mid_sp_plain: assert property (@(posedge pclk) disable iff (!presetn)
        s_take ##0 (!gates.double_precision_select && gates.gate_middle && !overflow)
        |=> result.coef[5:0] == $past(coef_sum[53:48]))
        else $error("middle segment plain single precision wrong");

    a_upper_gate_ones: assert property (@(posedge pclk) disable iff (!presetn)
        s_take ##0 (!gates.double_precision_select && !gates.gate_upper && !overflow)
        |=> &result.coef[47:6])
        else $error("upper segment not ones when gated off");

    a_lower_gate_ones: assert property (@(posedge pclk) disable iff (!presetn)
        s_take ##0 (gates.double_precision_select && !gates.gate_lower && !overflow)
        |=> &result.coef[44:0])
        else $error("lower segment not ones when gated off");

    a_shift_end_off: assert property (@(posedge pclk) disable iff (!presetn)
        s_take ##0 (gates.double_precision_select && gates.gate_lower && overflow)
        |=> result.coef[0] == $past(coef_sum[1]))
        else $error("overflow shift did not drop the lowest sum bit");

    a_upper_inert: assert property (@(posedge pclk) disable iff (!presetn)
        s_take ##0 (gates.double_precision_select && gates.gate_lower && gates.gate_middle
        && !overflow) |=> result.coef == $past(coef_sum[47:0]))
        else $error("upper gate changed a double precision result");

    a_pos_ovf_exp: assert property (@(posedge pclk) disable iff (!presetn)
        s_take ##0 (gates.gate_exponent && !sign_j && !sign_k && !top_borrow_out
        && work_exponent < 11'h7fe)
        |=> result.exp_field == {1'b0, ($past(work_exponent) + 11'h001) ^ 11'h400})
        else $error("positive overflow exponent not incremented");

    a_neg_ovf_exp: assert property (@(posedge pclk) disable iff (!presetn)
        s_take ##0 (gates.gate_exponent && sign_j && sign_k && top_borrow_out
        && work_exponent < 11'h7fe)
        |=> result.exp_field == ~{1'b0, ($past(work_exponent) + 11'h001) ^ 11'h400})
        else $error("negative overflow exponent wrong");

    a_unlike_pos_exp: assert property (@(posedge pclk) disable iff (!presetn)
        s_take ##0 (gates.gate_exponent && sign_j != sign_k && !top_borrow_out)
        |=> result.exp_field == {1'b0, $past(work_exponent) ^ 11'h400})
        else $error("positive larger exponent not in true form");

    a_unlike_sign: assert property (@(posedge pclk) disable iff (!presetn)
        s_take ##0 (sign_j != sign_k) |=> last_sign == $past(top_borrow_out))
        else $error("unlike signs gave the wrong result sign");

    a_idle_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(fourth_period && enable) |=> $stable(result))
        else $error("result changed outside a taken period");

    a_refused_valid: assert property (@(posedge pclk) disable iff (!presetn)
        (fourth_period && !enable) |=> !result_valid)
        else $error("result_valid raised while disabled");

endmodule : far_result_output

// ---- rtl/far_pkg.sv ----
// Constants and types shared by the float add result output stage.
package far_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [3:0] CTRL_OFF      = 4'h0;
    localparam logic [3:0] STATUS_OFF    = 4'h4;
    localparam logic [3:0] RESULT_LO_OFF = 4'h8;
    localparam logic [3:0] RESULT_HI_OFF = 4'hc;
    localparam int         CTRL_EN_BIT   = 0;
    localparam int         ST_OVF_BIT    = 0;
    localparam int         ST_SIGN_BIT   = 1;
    localparam int         ST_NZ_BIT     = 2;
    localparam logic       CTRL_RESET    = 1'b1;

    // ************************************************************
    // Datapath layout
    // ************************************************************
    localparam int          SUM_W        = 97;
    localparam int          COEF_W       = 48;
    localparam int          EXP_W        = 11;
    localparam int          SP_BASE      = 48;
    localparam int          LOWER_TOP    = 44;
    localparam int          MIDDLE_TOP   = 53;
    localparam logic [10:0] EXP_BIAS     = 11'h400;
    localparam logic [10:0] EXP_NEG_ONE  = 11'h7fe;
    localparam logic [10:0] EXP_POS_ZERO = 11'h000;

    typedef enum logic [1:0] {FAR_SEG_LOWER, FAR_SEG_MIDDLE, FAR_SEG_UPPER} far_seg_t;

    typedef struct packed {
        logic [11:0] exp_field;
        logic [47:0] coef;
    } far_result_t;

    typedef struct packed {
        logic gate_upper;
        logic gate_middle;
        logic gate_lower;
        logic gate_exponent;
        logic double_precision_select;
    } far_gates_t;

endpackage : far_pkg

// ---- test/far_dest_model.sv ----
// Destination operand register model that takes each delivered result word.
`timescale 1ns/1ps
module far_dest_model
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire far_pkg::far_result_t result,
    input  wire logic                 result_valid,
    output logic      [59:0]          dest_word,
    output logic      [7:0]           dest_writes
);
    // The whole word is written in one period, exponent above the coefficient.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dest_word   <= 60'h0;
            dest_writes <= 8'h0;
        end
        else if (result_valid)
        begin
            dest_word   <= {result.exp_field, result.coef};
            dest_writes <= dest_writes + 8'h1;
        end
    end
endmodule : far_dest_model

// ---- test/far_result_output_tb.sv ----
// Self-checking testbench of the float add result output stage.
`timescale 1ns/1ps
module far_result_output_tb;
    logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0]          paddr, pwdata, prdata, rd;
    logic [96:0]          coef_sum;
    logic [10:0]          work_exponent;
    logic                 sign_j, sign_k, top_borrow_out, fourth_period, result_valid, err;
    far_pkg::far_gates_t  gates;
    far_pkg::far_result_t result;
    logic [59:0]          dest_word, ev;
    logic [7:0]           dest_writes;
    logic [2:0]           st;
    int                   error_cnt, samples_checked;
    localparam logic [96:0] PAT = 97'h1_5a5a_c3c3_0ff0_9696_e187_2d4b;

    far_result_output far_result_output_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .coef_sum(coef_sum), .work_exponent(work_exponent),
        .sign_j(sign_j), .sign_k(sign_k), .top_borrow_out(top_borrow_out), .gates(gates),
        .fourth_period(fourth_period), .result(result), .result_valid(result_valid));
    far_dest_model far_dest_model_i (.pclk(pclk), .presetn(presetn), .result(result),
        .result_valid(result_valid), .dest_word(dest_word), .dest_writes(dest_writes));

    // *****************
    // Helpers
    // *****************
    task automatic chk(input logic [63:0] got, input logic [63:0] expv);
        samples_checked++;
        if (got !== expv)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, expv);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {24'h0, a}; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task automatic rdc(input logic [7:0] a, input logic [31:0] expv);
        apb(1'b0, a, 32'h0);
        chk({63'h0, err}, 64'h0);
        chk({32'h0, rd}, {32'h0, expv});
    endtask : rdc

    // Expected word and status {neg-zero fix, sign, overflow}.
    function automatic logic [59:0] model(input logic [96:0] s, input logic [10:0] e,
        input logic sj, input logic sk, input logic b, input logic [4:0] gv,
        output logic [2:0] so);
        far_pkg::far_gates_t g;
        logic ovf, neg, nz, gate;
        int idx;
        logic [11:0] ei, f;
        logic [47:0] c;
        g = far_pkg::far_gates_t'(gv);
        ovf = (sj == sk) && (sj ? b : !b);
        neg = (sj == sk) ? sj : b;
        nz = !sj && !sk && ovf && (e == far_pkg::EXP_NEG_ONE);
        for (int i = 0; i < 48; i++)
        begin
            idx = (g.double_precision_select ? 0 : 48) + int'(ovf) + i;
            gate = idx <= 44 ? g.gate_lower : (idx <= 53 ? g.gate_middle : g.gate_upper);
            c[i] = gate ? s[idx] : 1'b1;
        end
        ei = {1'b0, e} + {11'h0, ovf};
        ei = {1'b0, ei[10:0] + {10'h0, ei[11]}};
        if (nz) ei = 12'h0;
        f = {1'b0, ei[10:0] ^ far_pkg::EXP_BIAS};
        if (neg) f = ~f;
        if (!g.gate_exponent) f = 12'hfff;
        so = {nz, neg, ovf};
        return {f, c};
    endfunction : model

    task automatic op(input logic [10:0] e, input logic sj, input logic sk, input logic b,
        input logic [4:0] gv, input logic want);
        ev = model(PAT, e, sj, sk, b, gv, st);
        @(posedge pclk);
        coef_sum <= PAT; work_exponent <= e; sign_j <= sj; sign_k <= sk;
        top_borrow_out <= b; gates <= far_pkg::far_gates_t'(gv); fourth_period <= 1'b1;
        @(posedge pclk);
        fourth_period <= 1'b0;
        #1;
        chk({63'h0, result_valid}, {63'h0, want});
        if (want) chk({4'h0, result}, {4'h0, ev});
        if (want) @(posedge pclk);
        #1;
        if (want) chk({4'h0, dest_word}, {4'h0, ev});
    endtask : op

    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    // *****************
    // Clock, watchdog and tests
    // *****************
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    initial
    begin
        repeat (5000) @(posedge pclk);
        error_cnt++;
        wrap_up();
    end

    initial
    begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 32'h0;
        pwdata = 32'h0; coef_sum = 97'h0; work_exponent = 11'h0; sign_j = 1'b0;
        sign_k = 1'b0; top_borrow_out = 1'b0; gates = '0; fourth_period = 1'b0;
        error_cnt = 0; samples_checked = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdc({4'h0, far_pkg::CTRL_OFF}, 32'h1);
        rdc({4'h0, far_pkg::RESULT_LO_OFF}, 32'h0);
        apb(1'b0, 8'h02, 32'h0);
        chk({63'h0, err}, 64'h1);
        chk({32'h0, rd}, 64'h0);
        apb(1'b1, 8'h10, 32'h0);
        chk({63'h0, err}, 64'h1);
        rdc({4'h0, far_pkg::CTRL_OFF}, 32'h1);
        $display("test reset and unmapped done");
        for (int i = 0; i < 24; i++)
        begin
            op(i < 8 ? 11'h123 : (i < 16 ? 11'h7fe : 11'h3ff), i[2], i[1], i[0], 5'h1f,
               1'b1);
            rdc({4'h0, far_pkg::STATUS_OFF}, {29'h0, st});
        end
        rdc({4'h0, far_pkg::RESULT_LO_OFF}, ev[31:0]);
        rdc({4'h0, far_pkg::RESULT_HI_OFF}, {4'h0, ev[59:32]});
        $display("test sign and exponent paths done");
        for (int i = 0; i < 64; i++)
        begin
            op(11'h2a5, 1'b0, 1'b0, i[5], i[4:0],
               1'b1);
        end
        $display("test gate and precision sweep done");
        apb(1'b1, {4'h0, far_pkg::CTRL_OFF}, 32'h0);
        op(11'h001, 1'b1, 1'b1, 1'b1, 5'h1f, 1'b0);
        chk({4'h0, result}, {4'h0, model(PAT, 11'h2a5, 1'b0, 1'b0, 1'b1, 5'h1f, st)});
        apb(1'b1, {4'h0, far_pkg::CTRL_OFF}, 32'h1);
        rdc({4'h0, far_pkg::CTRL_OFF}, 32'h1);
        op(11'h001, 1'b1, 1'b1, 1'b1, 5'h1f, 1'b1);
        chk({56'h0, dest_writes}, 64'h59);
        $display("test enable control done");
        wrap_up();
    end
endmodule : far_result_output_tb
